// File: rtl/sbu_defs.vh
// sbu_defs.vh - constants for the serial bus unit control core
// assumes a 100 MHz pclk and a 32-bit apb register bus
`ifndef SBU_DEFS_VH
`define SBU_DEFS_VH
// --------------------------------------------------------------
// register byte offsets
// --------------------------------------------------------------
`define SBU_OFS_CTL1   8'h00
`define SBU_OFS_CTL2   8'h04
`define SBU_OFS_BUF    8'h08
`define SBU_OFS_ADR    8'h0c
// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define SBU_C1_BC      7:5
`define SBU_C1_ACK     4
`define SBU_C1_SCK     2:0
`define SBU_C2_MST     7
`define SBU_C2_TRX     6
`define SBU_C2_BB      5
`define SBU_C2_PIN     4
`define SBU_C2_MODE    3:2
`define SBU_C2_SWR     1:0
`define SBU_AR_SA      7:1
`define SBU_AR_ALS     0
// --------------------------------------------------------------
// codes and reset values
// --------------------------------------------------------------
`define SBU_MODE_BUS   2'b10
`define SBU_SWR_ARM    2'b10
`define SBU_SWR_FIRE   2'b01
`define SBU_BC_FULL    3'h0
`define SBU_NB_FULL    4'h8
`define SBU_GCALL      8'h00
`define SBU_PIN_RST    1'b1
`define SBU_PAD24      24'h000000
// --------------------------------------------------------------
// serial clock timing
// --------------------------------------------------------------
`define SBU_CLK_NS     10
`define SBU_TLOW_NS    1300
`define SBU_THIGH_NS   1200
`endif

// File: rtl/sbu_i2c.v
// sbu_i2c.v - two-wire serial bus control core, master or slave,
// apb register slave, open-drain scl/sda as in/out/oe triples.
// assumes pclk 100 MHz; scl/sda arrive asynchronously.
// Function
// - msb first out, receive right aligned
// - separate transmit and receive byte storage
// - own address bits 7-1, format bit 0
// - free data: master sends, slave receives
// - address 0x00 matches start byte 0x01
// - clock select sets master scl rate
// - scl fall restarts low count, drive low
// - high count waits for scl high
// - high count done drives scl low
// - ack mode adds ack clock, receiver acks
// - slave acknowledges general call address
// - no ack mode: slave still counts ack
// - start forces bit count to 000
// - free data: no address recognition
// - transmit select 1 sends, 0 receives
// - addressed slave loads direction into transmit
// - acked master inverts direction into transmit
// - stop or lost clears transmit select; in free data only a start on a busy bus clears it
// - stop or lost clears master select
// - start write sends buffered address byte
// - pending low holds scl until access
// - soft reset code 10 then 01
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "sbu_defs.vh"
module sbu_i2c #(
  parameter TLOW_CYC  = (`SBU_TLOW_NS + `SBU_CLK_NS - 1) / `SBU_CLK_NS,
  parameter THIGH_CYC = (`SBU_THIGH_NS + `SBU_CLK_NS - 1) / `SBU_CLK_NS,
  parameter CW        = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        scl_in,
  output wire        scl_out,
  output wire        scl_oe,
  input  wire        sda_in,
  output wire        sda_out,
  output wire        sda_oe
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_START = 5'h02;
  localparam [4:0] ST_BITS  = 5'h04;
  localparam [4:0] ST_HOLD  = 5'h08;
  localparam [4:0] ST_STOP  = 5'h10;
  localparam [31:0]   TLOW_W  = TLOW_CYC;
  localparam [31:0]   THIGH_W = THIGH_CYC;
  localparam [CW-1:0] TLOW_B  = TLOW_W[CW-1:0];
  localparam [CW-1:0] THIGH_B = THIGH_W[CW-1:0];

  reg  [2:0]    bc_ff;
  reg           ack_ff;
  reg  [2:0]    sck_ff;
  reg  [6:0]    sa_ff;
  reg           als_ff;
  reg  [7:0]    tx_ff;
  reg  [7:0]    rx_ff;
  reg           mst_ff;
  reg           trx_ff;
  reg           bb_ff;
  reg           pin_ff;
  reg           al_ff;
  reg           aas_ff;
  reg           ado_ff;
  reg           lrb_ff;
  reg  [1:0]    mode_ff;
  reg  [4:0]    state_ff;
  reg  [3:0]    cnt_ff;
  reg           pre_ff;
  reg           first_ff;
  reg  [7:0]    txsh_ff;
  reg           scl_low_ff;
  reg           sda_oe_ff;
  reg  [CW-1:0] tcnt_ff;
  reg  [31:0]   prdata_ff;
  reg           arm_ff;
  reg           swr_ff;
  reg  [2:0]    scl_sy_ff;
  reg  [2:0]    sda_sy_ff;

  // --------------------------------------------------------------
  // decode and bus conditions
  // --------------------------------------------------------------
  function is_ofs;
    input [7:0] a;
    input [7:0] o;
    begin
      is_ofs = (a == o);
    end
  endfunction

  wire mapped  = is_ofs(paddr, `SBU_OFS_CTL1) | is_ofs(paddr, `SBU_OFS_CTL2)
               | is_ofs(paddr, `SBU_OFS_BUF) | is_ofs(paddr, `SBU_OFS_ADR);
  wire acc     = psel & penable & mapped;
  wire wr      = acc & pwrite;
  wire c1_wr   = wr & is_ofs(paddr, `SBU_OFS_CTL1);
  wire c2_wr   = wr & is_ofs(paddr, `SBU_OFS_CTL2);
  wire ar_wr   = wr & is_ofs(paddr, `SBU_OFS_ADR);
  wire buf_acc = acc & is_ofs(paddr, `SBU_OFS_BUF);
  wire start_req = c2_wr & pwdata[`SBU_C2_MST] & pwdata[`SBU_C2_TRX]
                 & pwdata[`SBU_C2_BB] & pwdata[`SBU_C2_PIN];
  wire stop_req  = c2_wr & pwdata[`SBU_C2_MST] & pwdata[`SBU_C2_TRX]
                 & ~pwdata[`SBU_C2_BB] & pwdata[`SBU_C2_PIN];
  wire en      = (mode_ff == `SBU_MODE_BUS);
  wire rst_n   = presetn & ~swr_ff;

  wire scl_s   = scl_sy_ff[1];
  wire sda_s   = sda_sy_ff[1];
  wire scl_rise = scl_s & ~scl_sy_ff[2];
  wire scl_fall = ~scl_s & scl_sy_ff[2];
  wire start_det = ~sda_s & sda_sy_ff[2] & scl_s;
  wire stop_det  = sda_s & ~sda_sy_ff[2] & scl_s;

  wire       tx_eff = als_ff ? mst_ff : trx_ff;
  wire [3:0] nbits  = (bc_ff == `SBU_BC_FULL) ? `SBU_NB_FULL : {1'b0, bc_ff};
  wire [3:0] total  = nbits + {3'h0, ack_ff | ~mst_ff};
  wire [3:0] cnt_n  = cnt_ff + 4'h1;
  // zero address also hits start byte
  wire       hit    = (rx_ff[7:1] == sa_ff);
  wire       gcall  = (rx_ff == `SBU_GCALL);
  // low and high counts per select
  wire [CW-1:0] tlow  = TLOW_B << sck_ff;
  wire [CW-1:0] thigh = THIGH_B << sck_ff;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_in};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_in};
    end
  end

  // --------------------------------------------------------------
  // soft reset sequencer
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'b0;
      swr_ff <= 1'b0;
    end else begin
      swr_ff <= 1'b0;
      // arm on 10, fire on 01
      if (c2_wr && pwdata[`SBU_C2_MODE] == `SBU_MODE_BUS) begin
        if (pwdata[`SBU_C2_SWR] == `SBU_SWR_ARM) begin
          arm_ff <= 1'b1;
        end else if (pwdata[`SBU_C2_SWR] == `SBU_SWR_FIRE && arm_ff) begin
          arm_ff <= 1'b0;
          swr_ff <= 1'b1;
        end else begin
          arm_ff <= 1'b0;
        end
      end else if (c2_wr) begin
        arm_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // registers and bus engine
  // --------------------------------------------------------------
  always @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      bc_ff      <= 3'h0;
      ack_ff     <= 1'b0;
      sck_ff     <= 3'h0;
      sa_ff      <= 7'h00;
      als_ff     <= 1'b0;
      tx_ff      <= 8'h00;
      rx_ff      <= 8'h00;
      mst_ff     <= 1'b0;
      trx_ff     <= 1'b0;
      bb_ff      <= 1'b0;
      pin_ff     <= `SBU_PIN_RST;
      al_ff      <= 1'b0;
      aas_ff     <= 1'b0;
      ado_ff     <= 1'b0;
      lrb_ff     <= 1'b0;
      mode_ff    <= 2'h0;
      state_ff   <= ST_IDLE;
      cnt_ff     <= 4'h0;
      pre_ff     <= 1'b0;
      first_ff   <= 1'b0;
      txsh_ff    <= 8'h00;
      scl_low_ff <= 1'b0;
      sda_oe_ff  <= 1'b0;
      tcnt_ff    <= {CW{1'b0}};
    end else begin
      if (c1_wr) begin
        bc_ff  <= pwdata[`SBU_C1_BC];
        ack_ff <= pwdata[`SBU_C1_ACK];
        sck_ff <= pwdata[`SBU_C1_SCK];
      end
      if (ar_wr) begin
        sa_ff  <= pwdata[`SBU_AR_SA];
        als_ff <= pwdata[`SBU_AR_ALS];
      end
      if (buf_acc && pwrite) begin
        tx_ff <= pwdata[7:0];
      end
      if (buf_acc) begin
        pin_ff <= 1'b1;
        al_ff  <= 1'b0;
        aas_ff <= 1'b0;
      end
      if (c2_wr) begin
        mode_ff <= pwdata[`SBU_C2_MODE];
        al_ff   <= 1'b0;
        mst_ff  <= pwdata[`SBU_C2_MST];
        trx_ff  <= pwdata[`SBU_C2_TRX];
        if (pwdata[`SBU_C2_PIN]) begin
          pin_ff <= 1'b1;
        end
        if (start_req && en) begin
          if (bb_ff) begin
            al_ff  <= 1'b1;
            mst_ff <= 1'b0;
            trx_ff <= 1'b0;
          end else begin
            state_ff  <= ST_START;
            sda_oe_ff <= 1'b1;
            tcnt_ff   <= {CW{1'b0}};
          end
        end else if (stop_req && en && mst_ff) begin
          state_ff   <= ST_STOP;
          sda_oe_ff  <= 1'b1;
          scl_low_ff <= 1'b1;
          tcnt_ff    <= {CW{1'b0}};
        end
      end

      if (!en) begin
        state_ff   <= ST_IDLE;
        scl_low_ff <= 1'b0;
        sda_oe_ff  <= 1'b0;
      end else begin
        // master clock generation while shifting
        if (mst_ff && state_ff == ST_BITS) begin
          if (scl_low_ff) begin
            if (tcnt_ff >= tlow) begin
              scl_low_ff <= 1'b0;
              tcnt_ff    <= {CW{1'b0}};
            end else begin
              tcnt_ff <= tcnt_ff + 1'b1;
            end
          end else if (scl_fall) begin
            scl_low_ff <= 1'b1;
            tcnt_ff    <= {CW{1'b0}};
          end else if (!scl_s) begin
            tcnt_ff <= {CW{1'b0}};
          end else if (tcnt_ff >= thigh) begin
            scl_low_ff <= 1'b1;
            tcnt_ff    <= {CW{1'b0}};
          end else begin
            tcnt_ff <= tcnt_ff + 1'b1;
          end
        end

        case (state_ff)
          ST_IDLE: begin
            scl_low_ff <= 1'b0;
          end
          ST_START: begin
            if (tcnt_ff >= thigh) begin
              scl_low_ff <= 1'b1;
              tcnt_ff    <= {CW{1'b0}};
              state_ff   <= ST_BITS;
            end else begin
              tcnt_ff <= tcnt_ff + 1'b1;
            end
          end
          ST_BITS: begin
            if (scl_rise) begin
              lrb_ff <= sda_s;
              if (cnt_ff < nbits) begin
                rx_ff <= {rx_ff[6:0], sda_s};
                if (mst_ff && tx_eff && !sda_oe_ff && !sda_s) begin
                  al_ff      <= 1'b1;
                  mst_ff     <= 1'b0;
                  scl_low_ff <= 1'b0;
                  if (!als_ff) begin
                    trx_ff <= 1'b0;
                  end
                end
              end else if (mst_ff && first_ff && !als_ff && !sda_s) begin
                trx_ff <= ~tx_ff[0];
              end
            end
            if (scl_fall) begin
              if (pre_ff) begin
                pre_ff    <= 1'b0;
                txsh_ff   <= tx_ff;
                sda_oe_ff <= tx_eff & ~tx_ff[7];
              end else begin
                cnt_ff <= cnt_n;
                if (cnt_n == total) begin
                  state_ff   <= ST_HOLD;
                  pin_ff     <= 1'b0;
                  scl_low_ff <= 1'b1;
                  sda_oe_ff  <= 1'b0;
                  first_ff   <= 1'b0;
                end else if (cnt_n == nbits) begin
                  if (first_ff && !mst_ff && !als_ff) begin
                    if (hit || gcall) begin
                      aas_ff    <= 1'b1;
                      ado_ff    <= gcall;
                      trx_ff    <= rx_ff[0];
                      sda_oe_ff <= 1'b1;
                    end else begin
                      state_ff  <= ST_IDLE;
                      sda_oe_ff <= 1'b0;
                    end
                  end else begin
                    if (first_ff && als_ff && !mst_ff) begin
                      aas_ff <= 1'b1;
                    end
                    sda_oe_ff <= ~tx_eff & ack_ff;
                  end
                end else begin
                  txsh_ff   <= {txsh_ff[6:0], 1'b0};
                  sda_oe_ff <= tx_eff & ~txsh_ff[6];
                end
              end
            end
          end
          ST_HOLD: begin
            if (pin_ff) begin
              state_ff   <= ST_BITS;
              cnt_ff     <= 4'h0;
              txsh_ff    <= tx_ff;
              sda_oe_ff  <= tx_eff & ~tx_ff[7];
              scl_low_ff <= mst_ff;
              tcnt_ff    <= {CW{1'b0}};
            end else begin
              scl_low_ff <= 1'b1;
            end
          end
          ST_STOP: begin
            if (scl_low_ff) begin
              if (tcnt_ff >= tlow) begin
                scl_low_ff <= 1'b0;
                tcnt_ff    <= {CW{1'b0}};
              end else begin
                tcnt_ff <= tcnt_ff + 1'b1;
              end
            end else if (!scl_s) begin
              tcnt_ff <= {CW{1'b0}};
            end else if (tcnt_ff >= thigh) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= ST_IDLE;
            end else begin
              tcnt_ff <= tcnt_ff + 1'b1;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase

        if (start_det) begin
          bc_ff    <= `SBU_BC_FULL;
          bb_ff    <= 1'b1;
          ado_ff   <= 1'b0;
          cnt_ff   <= 4'h0;
          pre_ff   <= 1'b1;
          first_ff <= 1'b1;
          if (state_ff != ST_START) begin
            state_ff <= ST_BITS;
          end
        end
        if (stop_det) begin
          bb_ff      <= 1'b0;
          mst_ff     <= 1'b0;
          ado_ff     <= 1'b0;
          state_ff   <= ST_IDLE;
          scl_low_ff <= 1'b0;
          sda_oe_ff  <= 1'b0;
          if (!als_ff) begin
            trx_ff <= 1'b0;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------
  // apb read data, captured in the setup cycle
  // --------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SBU_OFS_CTL1: prdata_ff <= {`SBU_PAD24, bc_ff, ack_ff, 1'b0, sck_ff};
        `SBU_OFS_CTL2: prdata_ff <= {`SBU_PAD24, mst_ff, trx_ff, bb_ff,
                                     pin_ff, al_ff, aas_ff, ado_ff, lrb_ff};
        `SBU_OFS_BUF:  prdata_ff <= {`SBU_PAD24, rx_ff};
        `SBU_OFS_ADR:  prdata_ff <= {`SBU_PAD24, sa_ff, als_ff};
        default:       prdata_ff <= 32'h00000000;
      endcase
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_low_ff;
  assign sda_oe  = sda_oe_ff;

endmodule

// File: verification/sbu_i2c_chk.sv
// sbu_i2c_chk.sv - port-level assertions for the serial bus core
// assumes it is bound to sbu_i2c and sees only its ports
`timescale 1ns/1ps
module sbu_i2c_chk #(
  parameter TLOW_CYC  = 130,
  parameter THIGH_CYC = 120
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        scl_in,
  input wire        scl_out,
  input wire        scl_oe,
  input wire        sda_out,
  input wire        sda_oe
);
  reg  [7:0] hi_cnt_ff;
  reg  [7:0] lo_cnt_ff;
  wire [7:0] nxt_hi_cnt;
  wire [7:0] nxt_lo_cnt;
  // ----------------------------------------------------------
  // cycles the line stood high, cycles we held it low
  // ----------------------------------------------------------
  assign nxt_hi_cnt = !scl_in ? 8'h00 :
                      hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hff};
  assign nxt_lo_cnt = !scl_oe ? 8'h00 :
                      lo_cnt_ff + {7'h00, lo_cnt_ff != 8'hff};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff <= 8'h00;
      lo_cnt_ff <= 8'h00;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
      lo_cnt_ff <= nxt_lo_cnt;
    end
  end
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence
  sequence s_start;
    $rose(sda_oe) && scl_in && !scl_oe;
  endsequence
  a_ready_high: assert property (s_acc |-> pready)
    else $error("pready low in access");
  a_err_map: assert property (s_acc |->
    pslverr == (paddr > 8'h0c || paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  a_pad_zero: assert property (s_rd_setup ##1 s_acc |->
    prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("pin output value not low");
  a_rst_quiet: assert property ($rose(presetn) |-> !scl_oe && !sda_oe)
    else $error("pins driven after reset");
  a_low_min: assert property ($fell(scl_oe) |->
    lo_cnt_ff >= TLOW_CYC)
    else $error("clock low phase too short");
  a_high_min: assert property ($rose(scl_oe) && $past(scl_in) |->
    hi_cnt_ff >= THIGH_CYC)
    else $error("clock high phase too short");
  a_start_seq: assert property (s_start |->
    ##[1:300] $rose(scl_oe))
    else $error("no clock after start");
endmodule

// File: verification/sbu_i2c_tb.sv
// sbu_i2c_tb.sv - self-checking bench for the serial bus core
// assumes sbu_peer on the wires and sbu_i2c_chk bound below
`timescale 1ns/1ps
module sbu_i2c_tb;
  localparam [6:0] PEER_ADDR = 7'h2a;
  reg           pclk, presetn, psel, penable, pwrite, slow, e;
  reg  [7:0]    paddr, tx_byte, m_own, d;
  reg  [31:0]   pwdata, r;
  wire [31:0]   prdata;
  wire          pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
  wire          p_scl_oe, p_sda_oe, scl, sda;
  integer       fails, checks_done, seed, k;
  byte unsigned exp_q[$];
  assign scl = ~(scl_oe | p_scl_oe);
  assign sda = ~(sda_oe | p_sda_oe);
  always #5 pclk = ~pclk;
  sbu_i2c #(.TLOW_CYC(6), .THIGH_CYC(6)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  sbu_peer #(.ADDR(PEER_ADDR)) i_peer (
    .scl(scl), .sda(sda), .slow(slow), .tx_byte(tx_byte),
    .scl_oe(p_scl_oe), .sda_oe(p_sda_oe));
  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input [31:0] got, input [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input w, input [7:0] a, input [31:0] wd);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      fails = fails + 1;
      $display("[FAIL] %0t no pready", $time);
    end
  endtask
  task automatic wait_st(input integer idx, input v);
    integer n;
    n = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n = n + 1;
    end while (r[idx] !== v && n < 300);
    chk(r[idx], v);
  endtask
  task automatic chk_rst;
    for (k = 0; k < 4; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk(r, k == 1 ? 32'h10 : 32'h0);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // sequence
  // ----------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, slow, paddr} = 0;
    {pwdata, tx_byte} = 0;
    fails = 0;
    checks_done = 0;
    seed = 32'hd784;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 8'h10, 32'hff);
    apb(1'b0, 8'h10, 32'h0);
    chk({r[30:0], e}, 32'h1);
    chk_rst;
    m_own = 8'($random(seed)) & 8'hfe | 8'h02;
    apb(1'b1, 8'h0c, {24'h0, m_own});
    apb(1'b0, 8'h0c, 32'h0);
    chk(r, {24'h0, m_own});
    apb(1'b1, 8'h00, 32'hb0);
    chk({scl, sda}, 2'b11);
    for (k = 1; k >= 0; k--) begin
      apb(1'b1, 8'h04, k ? 32'h58 : 32'h18);
      apb(1'b0, 8'h04, 32'h0);
      chk(r[6], k);
    end
    apb(1'b1, 8'h08, {24'h0, PEER_ADDR, 1'b0});
    apb(1'b1, 8'h04, 32'hf8);
    wait_st(4, 1'b0);
    chk({r[7:5], r[0]}, 4'he);
    apb(1'b0, 8'h00, 32'h0);
    chk(r, 32'h10);
    repeat (20) @(posedge pclk);
    chk(scl_oe, 1'b1);
    slow <= 1'b1;
    d = 8'($random(seed));
    exp_q.push_back(d);
    apb(1'b1, 8'h08, {24'h0, d});
    wait_st(4, 1'b0);
    chk(i_peer.rxq.size(), 1);
    chk(i_peer.rxq.pop_front(), exp_q.pop_front());
    apb(1'b1, 8'h04, 32'hd8);
    wait_st(5, 1'b0);
    chk(r[7:6], 2'b00);
    slow <= 1'b0;
    tx_byte <= 8'($random(seed));
    apb(1'b1, 8'h08, {24'h0, PEER_ADDR, 1'b1});
    apb(1'b1, 8'h04, 32'hf8);
    wait_st(4, 1'b0);
    chk(r[7:6], 2'b10);
    apb(1'b0, 8'h08, 32'h0);
    wait_st(4, 1'b0);
    apb(1'b1, 8'h04, 32'hd8);
    wait_st(5, 1'b0);
    chk(r[7:6], 2'b00);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, {24'h0, tx_byte});
    apb(1'b1, 8'h04, 32'h1a);
    apb(1'b1, 8'h04, 32'h19);
    chk_rst;
    tally_and_finish;
  end
  // whole run needs under two thousand cycles; allow ten times that
  initial begin
    #200000;
    fails = fails + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
bind sbu_i2c sbu_i2c_chk #(.TLOW_CYC(TLOW_CYC), .THIGH_CYC(THIGH_CYC))
  i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe));

// File: verification/sbu_peer.sv
// sbu_peer.sv - behavioural two-wire slave facing the core
// assumes pulled-up scl/sda wires made by the bench
`timescale 1ns/1ps
module sbu_peer #(
  parameter [6:0] ADDR = 7'h2a
) (
  input  wire       scl,
  input  wire       sda,
  input  wire       slow,
  input  wire [7:0] tx_byte,
  output reg        scl_oe,
  output reg        sda_oe
);
  byte unsigned rxq[$];
  reg     [7:0] b;
  reg           stp;
  integer       i;
  // sample on scl rise; sda rising while scl high is a stop
  task automatic rd_bit(output reg v, output reg s);
    @(posedge scl);
    v = sda;
    @(negedge scl or posedge sda);
    s = scl;
  endtask
  task automatic rd_byte();
    reg v;
    for (i = 0; i < 8 && !stp; i++) begin
      rd_bit(v, stp);
      b = {b[6:0], v};
    end
  endtask
  task automatic ack_clk();
    #5 sda_oe = 1'b1;
    // stretch the low phase when asked
    if (slow) begin
      scl_oe = 1'b1;
      #300 scl_oe = 1'b0;
    end
    @(negedge scl);
    #5 sda_oe = 1'b0;
  endtask
  task automatic serve();
    stp = 1'b0;
    rd_byte();
    if (!stp && b[7:1] == ADDR) begin
      ack_clk();
      if (b[0]) begin
        for (i = 7; i >= 0; i--) begin
          #5 sda_oe = ~tx_byte[i];
          @(negedge scl);
        end
        #5 sda_oe = 1'b0;
      end else begin
        while (!stp) begin
          rd_byte();
          if (!stp) begin
            rxq.push_back(b);
            ack_clk();
          end
        end
      end
    end
  endtask
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    forever begin
      @(negedge sda);
      if (scl) begin
        serve();
      end
    end
  end
endmodule
